// ### verilog/alu_pkg.sv
/*
 * shared constants and types for the integer execution datapath:
 * operand widths, operation codes, multiply/divide commands and counts.
 * assumes a single core clock domain and a decoder that already
 * turned instruction fields into one of the operation codes below.
 */
package alu_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int DATA_W  = 32;
  localparam int SHAMT_W = 5;   // shift count width, immediate or variable
  localparam int STEP_W  = 5;   // divider step counter width

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam logic [STEP_W-1:0] DIV_FIRST = 5'h00;
  localparam logic [STEP_W-1:0] DIV_LAST  = 5'h1f;  // one quotient bit per step
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ONE_WORD  = 32'h0000_0001;
  localparam int SIGN_BIT = DATA_W - 1;

  // ****************************************************************
  // operation codes seen by the datapath
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_ADD_TRAP,
    OP_ADD_NOTRAP,
    OP_SUB_TRAP,
    OP_SUB_NOTRAP,
    OP_SET_LESS_SIGNED,
    OP_SET_LESS_UNSIGNED,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_NOR,
    OP_SHIFT_LEFT_LOGICAL_IMM,
    OP_SHIFT_RIGHT_LOGICAL_IMM,
    OP_SHIFT_RIGHT_ARITH_IMM,
    OP_SHIFT_LEFT_LOGICAL_VAR,
    OP_SHIFT_RIGHT_LOGICAL_VAR,
    OP_SHIFT_RIGHT_ARITH_VAR,
    OP_MULTIPLY_SIGNED,
    OP_MULTIPLY_UNSIGNED,
    OP_DIVIDE_SIGNED,
    OP_DIVIDE_UNSIGNED,
    OP_MOVE_FROM_HIGH,
    OP_MOVE_FROM_LOW
  } op_t;

  // commands handed to the multiply/divide unit
  typedef enum logic [1:0] {
    MD_MUL_SIGNED,
    MD_MUL_UNSIGNED,
    MD_DIV_SIGNED,
    MD_DIV_UNSIGNED
  } md_op_t;

endpackage

// ### verilog/md_if.sv
/*
 * carrier between the datapath core and its multiply/divide unit.
 * assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ns
interface md_if;
  import alu_pkg::*;

  logic                start;   // one-cycle command strobe
  md_op_t              op;
  logic [DATA_W-1:0]   a;
  logic [DATA_W-1:0]   b;
  logic                busy;    // divide in progress
  logic [DATA_W-1:0]   high;    // result_high_reg
  logic [DATA_W-1:0]   low;     // result_low_reg

  modport core (output start, output op, output a, output b,
                input busy, input high, input low);
  modport unit (input start, input op, input a, input b,
                output busy, output high, output low);
endinterface

// ### verilog/muldiv_unit.sv
/*
 * multiply/divide unit holding the high/low result pair.
 * assumes the core never issues a command while busy is high.
 */
`timescale 1ns/1ns
module muldiv_unit (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rstN,
  // command and result pair
  md_if.unit       md
);
  import alu_pkg::*;

  typedef enum logic {MD_IDLE, MD_DIVIDE} md_state_t;

  md_state_t           state_q;
  logic [DATA_W-1:0]   high_q;
  logic [DATA_W-1:0]   low_q;
  logic [DATA_W-1:0]   rem_q;
  logic [DATA_W-1:0]   quo_q;
  logic [DATA_W-1:0]   divisor_q;
  logic [STEP_W-1:0]   step_q;
  logic                negQuo_q;
  logic                negRem_q;
  logic [2*DATA_W-1:0] prodSigned;
  logic [2*DATA_W-1:0] prodUnsigned;
  logic                isSigned;
  logic [DATA_W-1:0]   magA;
  logic [DATA_W-1:0]   magB;
  logic [DATA_W-1:0]   remShift;
  logic [DATA_W:0]     trial;
  logic [DATA_W-1:0]   remNext;
  logic [DATA_W-1:0]   quoNext;

  // ****************************************************************
  // multiply: full products, sign- or zero-extended to double width
  // ****************************************************************
  assign prodSigned   = {{DATA_W{md.a[SIGN_BIT]}}, md.a}
                      * {{DATA_W{md.b[SIGN_BIT]}}, md.b};
  assign prodUnsigned = {ZERO_WORD, md.a} * {ZERO_WORD, md.b};

  // ****************************************************************
  // divide: restoring, one quotient bit a cycle on magnitudes
  // ****************************************************************
  assign isSigned = (md.op == MD_DIV_SIGNED);
  assign magA     = (isSigned && md.a[SIGN_BIT]) ? ZERO_WORD - md.a : md.a;
  assign magB     = (isSigned && md.b[SIGN_BIT]) ? ZERO_WORD - md.b : md.b;
  assign remShift = {rem_q[DATA_W-2:0], quo_q[SIGN_BIT]};
  assign trial    = {1'b0, remShift} - {1'b0, divisor_q};
  assign remNext  = trial[DATA_W] ? remShift : trial[DATA_W-1:0];
  assign quoNext  = {quo_q[DATA_W-2:0], ~trial[DATA_W]};

  // sequencing of a divide
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= MD_IDLE;
      step_q  <= DIV_FIRST;
    end else begin
      unique case (state_q)
        MD_IDLE: begin
          if (md.start && (md.op == MD_DIV_SIGNED || md.op == MD_DIV_UNSIGNED)) begin
            state_q <= MD_DIVIDE;
            step_q  <= DIV_FIRST;
          end
        end
        MD_DIVIDE: begin
          step_q <= step_q + 5'h01;
          if (step_q == DIV_LAST) begin
            state_q <= MD_IDLE;
          end
        end
      endcase
    end
  end

  // divider working registers; operands latched as magnitudes
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rem_q     <= ZERO_WORD;
      quo_q     <= ZERO_WORD;
      divisor_q <= ZERO_WORD;
      negQuo_q  <= 1'b0;
      negRem_q  <= 1'b0;
    end else if (state_q == MD_IDLE && md.start) begin
      rem_q     <= ZERO_WORD;
      quo_q     <= magA;
      divisor_q <= magB;
      negQuo_q  <= isSigned && (md.a[SIGN_BIT] ^ md.b[SIGN_BIT]);
      negRem_q  <= isSigned && md.a[SIGN_BIT];  // remainder takes dividend sign
    end else if (state_q == MD_DIVIDE) begin
      rem_q <= remNext;
      quo_q <= quoNext;
    end
  end

  // result pair: products land at once, quotients after the last step
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      high_q <= ZERO_WORD;
      low_q  <= ZERO_WORD;
    end else if (state_q == MD_IDLE && md.start && md.op == MD_MUL_SIGNED) begin
      high_q <= prodSigned[2*DATA_W-1:DATA_W];
      low_q  <= prodSigned[DATA_W-1:0];
    end else if (state_q == MD_IDLE && md.start && md.op == MD_MUL_UNSIGNED) begin
      high_q <= prodUnsigned[2*DATA_W-1:DATA_W];
      low_q  <= prodUnsigned[DATA_W-1:0];
    end else if (state_q == MD_DIVIDE && step_q == DIV_LAST) begin
      low_q  <= negQuo_q ? ZERO_WORD - quoNext : quoNext;
      high_q <= negRem_q ? ZERO_WORD - remNext : remNext;
    end
  end

  assign md.busy = (state_q == MD_DIVIDE);
  assign md.high = high_q;
  assign md.low  = low_q;
endmodule

// ### verilog/integer_alu_shift_muldiv.sv
/*
 * integer execution datapath of a 32-bit core: register arithmetic
 * with and without overflow trap, compares, bitwise logic, shifts and
 * a multiply/divide unit with move-from access to its result pair.
 * assumes the decoder and register file sit on the same clock, hand
 * in read operands with a decoded operation and take back the result
 * for the destination register one cycle after a request is taken.
 */
`timescale 1ns/1ns

// Behaviour
// - register operands in, register result out
// - trapping add traps on signed overflow
// - non-trapping add never traps
// - trapping subtract traps on signed overflow
// - signed compare writes one when smaller
// - unsigned compare writes one when smaller
// - and, or, xor, nor bit by bit
// - immediate left shift, zero fill low
// - immediate right logical, zero fill high
// - immediate right arithmetic copies sign bit
// - variable left shift, count from source a
// - variable right logical, count from source a
// - variable right arithmetic, count from source a
// - signed multiply fills high and low
// - move-from copies high or low out
module integer_alu_shift_muldiv (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // request from decode and register file
  input  wire logic                          reqValid,
  output logic                               reqReady,
  input  wire alu_pkg::op_t                  reqOp,
  input  wire logic [alu_pkg::DATA_W-1:0]    srcA,
  input  wire logic [alu_pkg::DATA_W-1:0]    srcB,
  input  wire logic [alu_pkg::SHAMT_W-1:0]   shiftAmount,
  // answer towards the register file
  output logic                               resValid,
  output logic [alu_pkg::DATA_W-1:0]         resData,
  output logic                               resTrap,
  // status
  output logic                               mdBusy
);
  import alu_pkg::*;

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rstSync_q;
  logic       rstN;

  // assert at once, release two edges later to keep release clean
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  // ****************************************************************
  // multiply/divide unit
  // ****************************************************************
  md_if mdBus ();

  muldiv_unit mdUnit (
    .clk  (clk),
    .rstN (rstN),
    .md   (mdBus.unit)
  );

  logic take;
  logic isMulDiv;

  // a divide in flight blocks every request; simpler than scoreboarding
  // the pair and costs only divide-heavy code
  assign reqReady = !mdBus.busy;
  assign take     = reqValid && reqReady;
  assign mdBusy   = mdBus.busy;

  assign isMulDiv = (reqOp == OP_MULTIPLY_SIGNED) || (reqOp == OP_MULTIPLY_UNSIGNED)
                 || (reqOp == OP_DIVIDE_SIGNED)   || (reqOp == OP_DIVIDE_UNSIGNED);

  // command mapping towards the unit
  always_comb begin
    mdBus.start = take && isMulDiv;
    mdBus.a     = srcA;
    mdBus.b     = srcB;
    mdBus.op    = MD_MUL_SIGNED;
    unique case (reqOp)
      OP_MULTIPLY_UNSIGNED: mdBus.op = MD_MUL_UNSIGNED;
      OP_DIVIDE_SIGNED:     mdBus.op = MD_DIV_SIGNED;
      OP_DIVIDE_UNSIGNED:   mdBus.op = MD_DIV_UNSIGNED;
      default:              mdBus.op = MD_MUL_SIGNED;
    endcase
  end

  // ****************************************************************
  // arithmetic and compare
  // ****************************************************************
  logic [DATA_W-1:0] sum;
  logic [DATA_W-1:0] diff;
  logic              addOverflow;
  logic              subOverflow;
  logic              lessSigned;
  logic              lessUnsigned;

  assign sum  = srcA + srcB;
  assign diff = srcA - srcB;

  // same-sign operands giving a result of the other sign
  assign addOverflow = (srcA[SIGN_BIT] == srcB[SIGN_BIT])
                    && (sum[SIGN_BIT] != srcA[SIGN_BIT]);
  // differing signs, result sign departs from the minuend
  assign subOverflow = (srcA[SIGN_BIT] != srcB[SIGN_BIT])
                    && (diff[SIGN_BIT] != srcA[SIGN_BIT]);

  assign lessSigned   = $signed(srcA) < $signed(srcB);
  assign lessUnsigned = srcA < srcB;

  // ****************************************************************
  // shifter
  // ****************************************************************
  logic [SHAMT_W-1:0] shiftCount;
  logic               isImmShift;
  logic [DATA_W-1:0]  shlOut;
  logic [DATA_W-1:0]  shrOut;
  logic [DATA_W-1:0]  sraOut;

  assign isImmShift = (reqOp == OP_SHIFT_LEFT_LOGICAL_IMM)
                   || (reqOp == OP_SHIFT_RIGHT_LOGICAL_IMM)
                   || (reqOp == OP_SHIFT_RIGHT_ARITH_IMM);

  // variable forms use only the low five bits of source a
  assign shiftCount = isImmShift ? shiftAmount
                                 : srcA[SHAMT_W-1:0];

  // the target is always source b
  assign shlOut = srcB << shiftCount;
  assign shrOut = srcB >> shiftCount;
  assign sraOut = DATA_W'($signed(srcB) >>> shiftCount);

  // ****************************************************************
  // result select
  // ****************************************************************
  logic [DATA_W-1:0] result;
  logic              trap;
  logic              writes;

  always_comb begin
    result = ZERO_WORD;
    trap   = 1'b0;
    writes = 1'b1;
    unique case (reqOp)
      OP_ADD_TRAP: begin
        result = sum;
        trap   = addOverflow;
      end
      OP_ADD_NOTRAP:              result = sum;
      OP_SUB_TRAP: begin
        result = diff;
        trap   = subOverflow;
      end
      OP_SUB_NOTRAP:              result = diff;
      OP_SET_LESS_SIGNED:         result = lessSigned ? ONE_WORD : ZERO_WORD;
      OP_SET_LESS_UNSIGNED:       result = lessUnsigned ? ONE_WORD : ZERO_WORD;
      OP_AND:                     result = srcA & srcB;
      OP_OR:                      result = srcA | srcB;
      OP_XOR:                     result = srcA ^ srcB;
      OP_NOR:                     result = ~(srcA | srcB);
      OP_SHIFT_LEFT_LOGICAL_IMM,
      OP_SHIFT_LEFT_LOGICAL_VAR:  result = shlOut;
      OP_SHIFT_RIGHT_LOGICAL_IMM,
      OP_SHIFT_RIGHT_LOGICAL_VAR: result = shrOut;
      OP_SHIFT_RIGHT_ARITH_IMM,
      OP_SHIFT_RIGHT_ARITH_VAR:   result = sraOut;
      OP_MULTIPLY_SIGNED,
      OP_MULTIPLY_UNSIGNED,
      OP_DIVIDE_SIGNED,
      OP_DIVIDE_UNSIGNED:         writes = 1'b0;           // only the pair changes
      OP_MOVE_FROM_HIGH:          result = mdBus.high;
      OP_MOVE_FROM_LOW:           result = mdBus.low;
      default:                    writes = 1'b0;           // undecoded code: no write
    endcase
  end

  // ****************************************************************
  // answer registers
  // ****************************************************************

  // write strobe; a trapped result never reaches the destination
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      resValid <= 1'b0;
      resTrap  <= 1'b0;
    end else begin
      resValid <= take && writes && !trap;
      resTrap  <= take && trap;
    end
  end

  // data held until the next taken request other than a multiply, a divide or an undecoded code
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      resData <= ZERO_WORD;
    end else if (take && writes) begin
      resData <= result;
    end
  end
endmodule

// ### dv/regfile_model.sv
/*
 * decode and register file model: reads two operands, issues one request
 * and grabs the answer for the destination register.
 * assumes it is entered at a falling edge of clk.
 */
`timescale 1ns/1ns
module regfile_model (
  // clock
  input  wire logic                       clk,
  // answer from the datapath
  input  wire logic                       reqReady,
  input  wire logic                       resValid,
  input  wire logic [alu_pkg::DATA_W-1:0] resData,
  input  wire logic                       resTrap,
  // request towards the datapath
  output alu_pkg::op_t                    reqOp,
  output logic                            reqValid,
  output logic [alu_pkg::DATA_W-1:0]      srcA,
  output logic [alu_pkg::DATA_W-1:0]      srcB,
  output logic [alu_pkg::SHAMT_W-1:0]     shiftAmount
);
  import alu_pkg::*;
  logic              gotValid;
  logic              gotTrap;
  logic [DATA_W-1:0] gotData;
  int                waits;
  bit                ok;

  // idle request at time zero
  initial begin
    reqValid = 1'b0;
    reqOp = OP_AND;
    srcA = 32'h0;
    srcB = 32'h0;
    shiftAmount = 5'h0;
  end

  // operands come from registers, the answer goes back to one
  task automatic issue(input op_t op, input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                       input logic [SHAMT_W-1:0] sh);
    waits = 0;
    reqValid = 1'b1;
    reqOp = op;
    srcA = a;
    srcB = b;
    shiftAmount = sh;
    // ready is steady at the falling edge, so the next rising edge takes it
    while (reqReady !== 1'b1 && waits < 40) begin
      @(negedge clk);
      waits++;
    end
    ok = (waits < 40);
    @(negedge clk);
    gotValid = resValid;
    gotTrap = resTrap;
    gotData = resData;
    // the request stays up: a following issue at this same edge then assigns it only once
  endtask

  // drop the request; only where a clock edge has passed since the last issue began
  task automatic rest();
    reqValid = 1'b0;
    srcA = ~srcA;  // released operands must not look like the last ones
    srcB = ~srcB;
  endtask
endmodule

// ### dv/integer_alu_shift_muldiv_assertions.sv
/*
 * checker for the integer datapath, watching the top ports only.
 * assumes one clock domain and answers one cycle after a take.
 */
`timescale 1ns/1ns
module integer_alu_shift_muldiv_assertions
  import alu_pkg::*;
(
  // clock and reset
  input wire logic                clk,
  input wire logic                nrst,
  // request
  input wire logic                reqValid,
  input wire logic                reqReady,
  input wire op_t                 reqOp,
  input wire logic [DATA_W-1:0]   srcA,
  input wire logic [DATA_W-1:0]   srcB,
  input wire logic [SHAMT_W-1:0]  shiftAmount,
  // answer
  input wire logic                resValid,
  input wire logic [DATA_W-1:0]   resData,
  input wire logic                resTrap,
  input wire logic                mdBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // reference values worked out from the operands
  logic              take;
  logic              addOvf;
  logic              subOvf;
  logic              lessS;
  logic [DATA_W-1:0] sum;
  logic [DATA_W-1:0] diff;
  logic [DATA_W-1:0] shift_right_arith_var;
  assign take = reqValid && reqReady;
  assign sum = srcA + srcB;
  assign diff = srcA - srcB;
  assign addOvf = (srcA[31] == srcB[31]) && (sum[31] != srcA[31]);
  assign subOvf = (srcA[31] != srcB[31]) && (diff[31] != srcA[31]);
  assign lessS = $signed(srcA) < $signed(srcB);
  assign shift_right_arith_var = $signed(srcB) >>> srcA[4:0];

  a_add_trap_ovf: assert property (take && reqOp == OP_ADD_TRAP && addOvf |=>
    resTrap && !resValid) else $error("add overflow did not trap");
  a_add_plain: assert property (take && reqOp == OP_ADD_NOTRAP |=>
    resValid && !resTrap && resData == $past(sum)) else $error("plain add wrong");
  a_sub_trap_ovf: assert property (take && reqOp == OP_SUB_TRAP && subOvf |=>
    resTrap && !resValid) else $error("sub overflow did not trap");
  a_sub_plain: assert property (take && reqOp == OP_SUB_NOTRAP |=>
    resValid && !resTrap && resData == $past(diff)) else $error("plain sub wrong");
  a_less_signed: assert property (take && reqOp == OP_SET_LESS_SIGNED |=>
    resData == {31'h0, $past(lessS)}) else $error("signed compare wrong");
  a_shift_arith: assert property (take && reqOp == OP_SHIFT_RIGHT_ARITH_VAR |=>
    resData == $past(shift_right_arith_var)) else $error("variable arithmetic shift wrong");
  a_div_busy_span: assert property (take && reqOp inside {OP_DIVIDE_SIGNED,
    OP_DIVIDE_UNSIGNED} |=> mdBusy ##31 mdBusy ##1 !mdBusy) else $error("divide busy span");
  a_pulse_cause: assert property (resValid || resTrap |-> $past(take))
    else $error("answer without a request");
  a_ready_busy: assert property (reqReady == !mdBusy)
    else $error("ready does not follow busy");
  a_busy_silent: assert property (mdBusy |-> !resValid && !resTrap)
    else $error("answer during a divide");
endmodule

bind integer_alu_shift_muldiv integer_alu_shift_muldiv_assertions chk_u (
  .clk(clk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
  .srcA(srcA), .srcB(srcB), .shiftAmount(shiftAmount), .resValid(resValid),
  .resData(resData), .resTrap(resTrap), .mdBusy(mdBusy));

// ### dv/test_integer_alu_shift_muldiv.sv
/*
 * self-checking bench for the integer datapath with a register file model.
 * assumes the design answers one cycle after a take, stalls on divide.
 */
`timescale 1ns/1ns
module test_integer_alu_shift_muldiv;
  import alu_pkg::*;
  logic              clk;
  logic              nrst;
  logic              reqValid;
  logic              reqReady;
  op_t               reqOp;
  logic [DATA_W-1:0] srcA;
  logic [DATA_W-1:0] srcB;
  logic [4:0]        shiftAmount;
  logic              resValid;
  logic [DATA_W-1:0] resData;
  logic              resTrap;
  logic              mdBusy;
  int                n_fail = 0;
  int                n_tests = 0;

  integer_alu_shift_muldiv dut_u (.clk(clk), .nrst(nrst), .reqValid(reqValid),
    .reqReady(reqReady), .reqOp(reqOp), .srcA(srcA), .srcB(srcB), .shiftAmount(shiftAmount),
    .resValid(resValid), .resData(resData), .resTrap(resTrap), .mdBusy(mdBusy));
  regfile_model model_u (.clk(clk), .reqReady(reqReady), .resValid(resValid),
    .resData(resData), .resTrap(resTrap), .reqOp(reqOp), .reqValid(reqValid), .srcA(srcA),
    .srcB(srcB), .shiftAmount(shiftAmount));

  // 20 MHz core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ************************************************************
  // compare and report
  // ************************************************************
  task automatic results();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkFlag(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask

  // one request; a trap must suppress the write, mul/div must answer nothing
  task automatic alu(input op_t op, input logic [31:0] a, input logic [31:0] b,
                     input logic [4:0] sh, input logic [31:0] exp, input logic trap,
                     input logic writes);
    model_u.issue(op, a, b, sh);
    if (!model_u.ok) begin
      n_fail++;
      $display("unexpected reqReady: expected 1 seen %b", reqReady);
      results();
    end else begin
      chkFlag("trap", trap, model_u.gotTrap);
      chkFlag("valid", writes && !trap, model_u.gotValid);
      if (writes && !trap) chkWord("result", exp, model_u.gotData);
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_arith();
    alu(OP_ADD_TRAP, 32'h7fff_ffff, 32'h0000_0001, 5'h0, 32'h0, 1'b1, 1'b1);
    alu(OP_ADD_TRAP, 32'h0000_0005, 32'hffff_fffd, 5'h0, 32'h2, 1'b0, 1'b1);
    alu(OP_ADD_NOTRAP, 32'h7fff_ffff, 32'h1, 5'h0, 32'h8000_0000, 1'b0, 1'b1);
    alu(OP_SUB_TRAP, 32'h8000_0000, 32'h1, 5'h0, 32'h0, 1'b1, 1'b1);
    alu(OP_SUB_TRAP, 32'h3, 32'h5, 5'h0, 32'hffff_fffe, 1'b0, 1'b1);
    alu(OP_SUB_NOTRAP, 32'h8000_0000, 32'h1, 5'h0, 32'h7fff_ffff, 1'b0, 1'b1);
  endtask
  task automatic t_compare_logic();
    alu(OP_SET_LESS_SIGNED, 32'hffff_ffff, 32'h1, 5'h0, 32'h1, 1'b0, 1'b1);
    alu(OP_SET_LESS_SIGNED, 32'h1, 32'h1, 5'h0, 32'h0, 1'b0, 1'b1);
    alu(OP_SET_LESS_UNSIGNED, 32'hffff_ffff, 32'h1, 5'h0, 32'h0, 1'b0, 1'b1);
    alu(OP_SET_LESS_UNSIGNED, 32'h1, 32'hffff_ffff, 5'h0, 32'h1, 1'b0, 1'b1);
    alu(OP_AND, 32'hf0f0_ff00, 32'hff00_0ff0, 5'h0, 32'hf000_0f00, 1'b0, 1'b1);
    alu(OP_OR, 32'hf0f0_ff00, 32'hff00_0ff0, 5'h0, 32'hfff0_fff0, 1'b0, 1'b1);
    alu(OP_XOR, 32'hf0f0_ff00, 32'hff00_0ff0, 5'h0, 32'h0ff0_f0f0, 1'b0, 1'b1);
    alu(OP_NOR, 32'hf0f0_ff00, 32'hff00_0ff0, 5'h0, 32'h000f_000f, 1'b0, 1'b1);
  endtask
  // source a carries a decoy count for immediate forms, the field a decoy for variable ones
  task automatic t_shift();
    alu(OP_SHIFT_LEFT_LOGICAL_IMM, 32'h4, 32'h8000_0001, 5'h1f,
        32'h8000_0000, 1'b0, 1'b1);
    alu(OP_SHIFT_RIGHT_LOGICAL_IMM, 32'h4, 32'h8000_0001, 5'h1f,
        32'h1, 1'b0, 1'b1);
    alu(OP_SHIFT_RIGHT_ARITH_IMM, 32'h0, 32'h8000_0001, 5'h04,
        32'hf800_0000, 1'b0, 1'b1);
    alu(OP_SHIFT_LEFT_LOGICAL_VAR, 32'hffff_ffe4, 32'h8000_0001, 5'h1f,
        32'h10, 1'b0, 1'b1);
    alu(OP_SHIFT_RIGHT_LOGICAL_VAR, 32'hffff_ffe4, 32'h8000_0001, 5'h1f,
        32'h0800_0000, 1'b0, 1'b1);
    alu(OP_SHIFT_RIGHT_ARITH_VAR, 32'hffff_ffe4, 32'h8000_0001, 5'h1f,
        32'hf800_0000, 1'b0, 1'b1);
  endtask
  // move-from taken on the very next edge after a multiply
  task automatic t_multiply();
    alu(OP_MULTIPLY_SIGNED, 32'hffff_ffff, 32'h2, 5'h0, 32'h0, 1'b0, 1'b0);
    alu(OP_MOVE_FROM_HIGH, 32'h0, 32'h0, 5'h0, 32'hffff_ffff, 1'b0, 1'b1);
    alu(OP_MOVE_FROM_LOW, 32'h0, 32'h0, 5'h0, 32'hffff_fffe, 1'b0, 1'b1);
    alu(OP_MULTIPLY_UNSIGNED, 32'hffff_ffff, 32'h2, 5'h0, 32'h0, 1'b0, 1'b0);
    alu(OP_MOVE_FROM_HIGH, 32'h0, 32'h0, 5'h0, 32'h1, 1'b0, 1'b1);
    alu(OP_MOVE_FROM_LOW, 32'h0, 32'h0, 5'h0, 32'hffff_fffe, 1'b0, 1'b1);
  endtask
  // the move-from right behind a divide is refused for the whole divide
  task automatic t_divide();
    alu(OP_DIVIDE_UNSIGNED, 32'h64, 32'h7, 5'h0, 32'h0, 1'b0, 1'b0);
    chkFlag("busy", 1'b1, mdBusy);
    alu(OP_MOVE_FROM_LOW, 32'h0, 32'h0, 5'h0, 32'he, 1'b0, 1'b1);
    chkWord("stall", 32'd32, model_u.waits);
    alu(OP_MOVE_FROM_HIGH, 32'h0, 32'h0, 5'h0, 32'h2, 1'b0, 1'b1);
    alu(OP_DIVIDE_SIGNED, 32'hffff_fff9, 32'h2, 5'h0, 32'h0, 1'b0, 1'b0);
    alu(OP_MOVE_FROM_HIGH, 32'h0, 32'h0, 5'h0, 32'hffff_ffff, 1'b0, 1'b1);
    alu(OP_MOVE_FROM_LOW, 32'h0, 32'h0, 5'h0, 32'hffff_fffd, 1'b0, 1'b1);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chkWord("reset data", 32'h0, resData);
    chkFlag("reset ready", 1'b1, reqReady);
    chkFlag("reset busy", 1'b0, mdBusy);
    t_arith();
    t_compare_logic();
    t_shift();
    t_multiply();
    t_divide();
    model_u.rest();
    results();
  end
endmodule
